// [rtl/fan_pwm_and_tach_monitor.sv]
// Two-channel fan drive modulator and tachometer period monitor with its runtime registers.
`timescale 1ns/100ps

// One fan channel: drive modulator plus tachometer counter.
module fan_channel
  import fan_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire chan_cfg_t i_cfg,
  input wire logic i_slow_tick,
  input wire logic i_tach,
  input wire logic i_preload_wr,
  input wire logic [7:0] i_preload,
  output logic o_drive,
  output logic [7:0] o_count,
  output logic o_slow
);

  // Step interval for each frequency choice, rounded down to whole cycles.
  function automatic logic [15:0] step_cycles(input logic [2:0] sel);
    step_cycles = 16'(CLK_HZ / (FOUT_HZ[sel] * PWM_STEPS));
  endfunction : step_cycles

  logic [2:0] freq_sel; // Frequency table index.
  logic [15:0] step_cnt; // Cycles within the current duty step.
  logic step_tick; // One-cycle pulse at each duty step.
  logic [5:0] phase; // Position within the output period.
  logic [2:0] sync; // Tach synchronizer and edge history.
  logic tach_rise; // Rising edge on the synchronized tach.
  logic [2:0] pre_cnt; // Slow-tick prescaler.
  logic tach_tick; // Divided counting clock tick.
  logic [2:0] div_last; // Terminal prescaler value for the divisor.

  assign freq_sel = {i_cfg.multiplier, i_cfg.source_select, i_cfg.clock_select};
  assign step_tick = (step_cnt >= step_cycles(freq_sel) - 16'h0001);

  // Step interval counter; a rate change applies to the step in progress, ending it at once if already past the new limit, which is harmless.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      step_cnt <= 16'h0000;
    end else if (step_tick) begin
      step_cnt <= 16'h0000;
    end else begin
      step_cnt <= step_cnt + 16'h0001;
    end
  end

  // Phase walks through the 64 steps of one output period.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      phase <= 6'h00;
    end else if (step_tick) begin
      phase <= phase + 6'h01;
    end
  end

  // Drive output register.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_drive <= 1'b0;
    end else if (i_cfg.override_high) begin
      o_drive <= 1'b1;
    end else begin
      o_drive <= (phase < i_cfg.duty_field);
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      // The tach line idles high through its pull-up; resetting to ones avoids a false edge.
      sync <= 3'h7;
    end else begin
      sync <= {sync[1:0], i_tach};
    end
  end
  assign tach_rise = sync[1] & ~sync[2];

  assign div_last = 3'((4'h1 << i_cfg.divisor) - 4'h1);
  assign tach_tick = i_slow_tick && (pre_cnt >= div_last);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pre_cnt <= 3'h0;
    end else if (tach_rise || i_preload_wr || tach_tick) begin
      pre_cnt <= 3'h0;
    end else if (i_slow_tick) begin
      pre_cnt <= pre_cnt + 3'h1;
    end
  end

  // Tachometer period counter.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_count <= RST_PRELOAD;
    end else if (i_preload_wr) begin
      o_count <= i_preload;
    end else if (tach_rise) begin
      o_count <= i_preload;
    end else if (tach_tick && (o_count != COUNT_MAX)) begin
      o_count <= o_count + 8'h01;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_slow <= 1'b0;
    end else begin
      o_slow <= (o_count[7:6] == SLOW_MSBS);
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  // A restart request seen at the counter.
  sequence s_restart;
    tach_rise || i_preload_wr;
  endsequence

  // A counting tick with no restart.
  sequence s_count_step;
    tach_tick && !tach_rise && !i_preload_wr && (o_count != COUNT_MAX);
  endsequence

  a_override_high: assert property (i_cfg.override_high |=> o_drive)
    else $error("Override did not hold drive high.");
  a_zero_duty_low: assert property
    ((!i_cfg.override_high && i_cfg.duty_field == 6'h00)[*2] |-> !o_drive)
    else $error("Zero duty drove output high.");
  a_max_duty_low: assert property
    (!i_cfg.override_high && i_cfg.duty_field == 6'h3F && phase == 6'h3F |=> !o_drive)
    else $error("Max duty missed its low step.");
  a_restart_load: assert property (s_restart |=> o_count == $past(i_preload))
    else $error("Restart did not load preload.");
  a_count_up: assert property (s_count_step |=> o_count == $past(o_count) + 8'h01)
    else $error("Counter did not step up.");
  a_saturate_hold: assert property
    (o_count == COUNT_MAX && !tach_rise && !i_preload_wr |=> o_count == COUNT_MAX)
    else $error("Counter wrapped past FF.");
  a_idle_stable: assert property
    (!tach_tick && !tach_rise && !i_preload_wr |=> $stable(o_count))
    else $error("Counter moved without a tick.");
  a_slow_flag: assert property (o_count[7:6] == SLOW_MSBS |=> o_slow)
    else $error("Slow flag missed count of 192.");
  a_edge_sync: assert property (tach_rise |-> $past(i_tach, 2) && !$past(i_tach, 3))
    else $error("Edge not from synchronized tach.");
  a_reset_low: assert property (disable iff (1'b0) !i_rst_n |=> !o_drive)
    else $error("Drive not low after reset.");

endmodule : fan_channel

// Top: runtime registers, slow clock selection and two channels.
module fan_pwm_and_tach_monitor
  import fan_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic i_slow_clock_present_bit,
  input wire logic i_slow_clock_pin,
  input wire logic [1:0] i_wake_enable_group_1,
  input wire logic [1:0] i_sysmgmt_enable_group_5,
  input wire logic i_tach_input_a,
  input wire logic i_tach_input_b,
  output logic o_drive_output_a,
  output logic o_drive_output_b,
  output logic o_wake_event,
  output logic o_sysmgmt_interrupt
);

  logic [7:0] drive_a; // Channel A drive setting.
  logic [7:0] drive_b; // Channel B drive setting.
  logic [7:0] config_reg; // Shared divisor and clock config.
  logic [7:0] preload_a; // Channel A preload.
  logic [7:0] preload_b; // Channel B preload.
  logic [8:0] int_div; // Internal slow clock divider.
  logic [2:0] pin_sync; // Slow clock pin synchronizer.
  logic slow_tick; // Selected slow clock tick.
  chan_cfg_t cfg_a; // Channel A settings.
  chan_cfg_t cfg_b; // Channel B settings.
  logic [7:0] count_a; // Channel A counter.
  logic [7:0] count_b; // Channel B counter.
  logic [1:0] slow; // Per-channel slow flags.
  logic drive_a_w; // Channel A drive flop.
  logic drive_b_w; // Channel B drive flop.

  // Register writes; each register is its own concern.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      drive_a <= RST_DRIVE;
      drive_b <= RST_DRIVE;
      config_reg <= RST_CONFIG;
      preload_a <= RST_PRELOAD;
      preload_b <= RST_PRELOAD;
    end else if (i_wr_en) begin
      case (i_addr)
        ADDR_DRIVE_A: drive_a <= i_wdata;
        ADDR_DRIVE_B: drive_b <= i_wdata;
        ADDR_CONFIG: config_reg <= i_wdata;
        ADDR_PRELOAD_A: preload_a <= i_wdata;
        ADDR_PRELOAD_B: preload_b <= i_wdata;
        default: ;
      endcase
    end
  end

  // Registered read port; unmapped offsets read as zero.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd_en) begin
      case (i_addr)
        ADDR_DRIVE_A: o_rdata <= drive_a;
        ADDR_DRIVE_B: o_rdata <= drive_b;
        ADDR_CONFIG: o_rdata <= config_reg;
        ADDR_PRELOAD_A: o_rdata <= preload_a;
        ADDR_PRELOAD_B: o_rdata <= preload_b;
        ADDR_COUNT_A: o_rdata <= count_a;
        ADDR_COUNT_B: o_rdata <= count_b;
        default: o_rdata <= 8'h00;
      endcase
    end
  end

  // Internal slow clock is an approximation of 32.768 kHz; a real crystal on the pin is better.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      int_div <= 9'h000;
    end else if (int_div >= 9'(SLOW_DIV - 1)) begin
      int_div <= 9'h000;
    end else begin
      int_div <= int_div + 9'h001;
    end
  end

  // Slow clock pin synchronizer with edge history.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pin_sync <= 3'h0;
    end else begin
      pin_sync <= {pin_sync[1:0], i_slow_clock_pin};
    end
  end

  assign slow_tick = i_slow_clock_present_bit ? (pin_sync[1] & ~pin_sync[2])
                                              : (int_div >= 9'(SLOW_DIV - 1));

  assign cfg_a = '{duty_field: drive_a[DUTY_HI:DUTY_LO], clock_select: drive_a[CLKSEL_BIT],
                   override_high: drive_a[OVERRIDE_BIT], multiplier: config_reg[MULT_A_BIT],
                   source_select: config_reg[SRC_A_BIT], divisor: config_reg[DIV_A_HI:DIV_A_LO]};
  assign cfg_b = '{duty_field: drive_b[DUTY_HI:DUTY_LO], clock_select: drive_b[CLKSEL_BIT],
                   override_high: drive_b[OVERRIDE_BIT], multiplier: config_reg[MULT_B_BIT],
                   source_select: config_reg[SRC_B_BIT], divisor: config_reg[DIV_B_HI:DIV_B_LO]};

  fan_channel u_chan_a (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_cfg(cfg_a),
    .i_slow_tick(slow_tick),
    .i_tach(i_tach_input_a),
    .i_preload_wr(i_wr_en && (i_addr == ADDR_PRELOAD_A)),
    .i_preload(i_wdata),
    .o_drive(drive_a_w),
    .o_count(count_a),
    .o_slow(slow[0])
  );

  fan_channel u_chan_b (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_cfg(cfg_b),
    .i_slow_tick(slow_tick),
    .i_tach(i_tach_input_b),
    .i_preload_wr(i_wr_en && (i_addr == ADDR_PRELOAD_B)),
    .i_preload(i_wdata),
    .o_drive(drive_b_w),
    .o_count(count_b),
    .o_slow(slow[1])
  );

  // Drive pins come straight from the channel flip-flops.
  assign o_drive_output_a = drive_a_w;
  assign o_drive_output_b = drive_b_w;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_wake_event <= 1'b0;
      o_sysmgmt_interrupt <= 1'b0;
    end else begin
      o_wake_event <= |(slow & i_wake_enable_group_1);
      o_sysmgmt_interrupt <= |(slow & i_sysmgmt_enable_group_5);
    end
  end

  a_wake_gate: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (slow & i_wake_enable_group_1) == 2'h0 |=> !o_wake_event)
    else $error("Wake raised while disabled.");

endmodule : fan_pwm_and_tach_monitor

// [rtl/fan_pkg.sv]
// Constants, register map and field layouts for the two-channel fan drive and tachometer block.
package fan_pkg;

  // System clock rate in Hz.
  localparam int unsigned CLK_HZ = 10_000_000;
  // Nominal slow counting clock rate in Hz.
  localparam int unsigned SLOW_HZ = 32_768;
  // Cycles of the system clock per internally derived slow clock tick.
  localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_HZ;
  // Steps in one drive output period.
  localparam int unsigned PWM_STEPS = 64;

  // Drive output frequencies in Hz, indexed by {multiplier, source select, clock select}.
  // The multiplier is the top index bit, so setting it doubles whatever the other two pick.
  localparam int unsigned FOUT_HZ [8] = '{15_625, 23_438, 40, 60, 31_250, 46_876, 80, 120};

  // Register byte offsets.
  localparam logic [7:0] ADDR_DRIVE_A = 8'h56;
  localparam logic [7:0] ADDR_DRIVE_B = 8'h57;
  localparam logic [7:0] ADDR_CONFIG = 8'h58;
  localparam logic [7:0] ADDR_PRELOAD_A = 8'h59;
  localparam logic [7:0] ADDR_PRELOAD_B = 8'h5A;
  localparam logic [7:0] ADDR_COUNT_A = 8'h5B;
  localparam logic [7:0] ADDR_COUNT_B = 8'h5C;

  // Reset values: divisor fields default to divide-by-2 (code 01).
  localparam logic [7:0] RST_CONFIG = 8'h50;
  localparam logic [7:0] RST_DRIVE = 8'h00;
  localparam logic [7:0] RST_PRELOAD = 8'h00;

  // Field positions in the fan_channel_drive_setting register.
  localparam int CLKSEL_BIT = 7;
  localparam int DUTY_HI = 6;
  localparam int DUTY_LO = 1;
  localparam int OVERRIDE_BIT = 0;

  // Field positions in the fan_tach_and_clock_config register.
  localparam int DIV_A_HI = 7;
  localparam int DIV_A_LO = 6;
  localparam int DIV_B_HI = 5;
  localparam int DIV_B_LO = 4;
  localparam int MULT_A_BIT = 3;
  localparam int MULT_B_BIT = 2;
  localparam int SRC_A_BIT = 1;
  localparam int SRC_B_BIT = 0;

  // Counter limits.
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [1:0] SLOW_MSBS = 2'h3;

  // Settings that steer one channel.
  typedef struct packed {
    logic [5:0] duty_field;
    logic clock_select;
    logic override_high;
    logic multiplier;
    logic source_select;
    logic [1:0] divisor;
  } chan_cfg_t;

endpackage : fan_pkg

// [dv/fan_model.sv]
// Behavioural cooling fan that answers the drive output with tachometer pulses.
`timescale 1ns/100ps
module fan_model (
  input wire logic i_drive,
  input wire logic i_run,
  input wire logic [31:0] i_rev_ns,
  output logic o_tach
);
  // The tach output is open collector with a pull-up, so a stopped fan reads high.
  initial o_tach = 1'b1;
  // The fan only turns while enabled and seeing drive; short low pulse per half turn.
  // two pulses per revolution
  always begin
    wait (i_run && i_drive);
    #(i_rev_ns / 2 - i_rev_ns / 8) o_tach = 1'b0;
    #(i_rev_ns / 8) o_tach = 1'b1;
  end
endmodule : fan_model

// [dv/tb.sv]
// Self-checking bench for the fan drive and tachometer block.
`timescale 1ns/100ps
module tb;
  import fan_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] o_rdata;
  logic present = 1'b0;
  logic slow_pin = 1'b0;
  logic run = 1'b0;
  logic [1:0] wake_en = 2'h0;
  logic [1:0] smi_en = 2'h0;
  logic tach_a, tach_b, drv_a, drv_b, wake, sysmgmt_interrupt;
  logic [7:0] rd;
  logic [5:0] da, db;
  logic [2:0] idx;
  int error_cnt = 0;
  int total_checks = 0;
  int ha, hb, st, p, q;

  // System clock at 10 MHz and a free-running external slow clock near 32.768 kHz.
  always #50 i_clock = ~i_clock;
  always #15259 slow_pin = ~slow_pin;

  fan_pwm_and_tach_monitor DUT (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .i_slow_clock_present_bit(present), .i_slow_clock_pin(slow_pin),
    .i_wake_enable_group_1(wake_en), .i_sysmgmt_enable_group_5(smi_en),
    .i_tach_input_a(tach_a), .i_tach_input_b(tach_b), .o_drive_output_a(drv_a),
    .o_drive_output_b(drv_b), .o_wake_event(wake), .o_sysmgmt_interrupt(sysmgmt_interrupt));
  // Two fans with different speeds so the tach rises of the two channels fall at different times.
  fan_model fan_a (.i_drive(drv_a), .i_run(run), .i_rev_ns(32'd400000), .o_tach(tach_a));
  fan_model fan_b (.i_drive(drv_b), .i_run(run), .i_rev_ns(32'd520000), .o_tach(tach_b));

  // One-cycle write strobe, launched at the falling edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clock);
    i_addr = a;
    i_wdata = d;
    i_wr_en = 1'b1;
    @(negedge i_clock);
    i_wr_en = 1'b0;
  endtask : wr

  // One-cycle read strobe; data is registered, so it is taken a cycle later.
  task automatic rdr(input logic [7:0] a);
    @(negedge i_clock);
    i_addr = a;
    i_rd_en = 1'b1;
    @(negedge i_clock);
    i_rd_en = 1'b0;
    rd = o_rdata;
  endtask : rdr

  // Exact comparison of a byte.
  task automatic check_eq(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check_eq

  // Range comparison, for counts whose prescaler phase is not known.
  task automatic check_rng(input logic [15:0] got, input int lo, input int hi);
    total_checks++;
    if ($isunknown(got) || got < lo || got > hi) begin
      error_cnt++;
      $display("unexpected at %0t: got %0d want %0d..%0d", $time, got, lo, hi);
    end
  endtask : check_rng

  // Count the high cycles of both drive outputs over n cycles.
  task automatic measure(input int n);
    ha = 0;
    hb = 0;
    repeat (n) begin
      @(negedge i_clock);
      ha += int'(drv_a === 1'b1);
      hb += int'(drv_b === 1'b1);
    end
  endtask : measure

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  // Watchdog: the sequence needs about 4 ms, so 8 ms means a hang.
  initial begin
    #8_000_000;
    error_cnt++;
    end_of_test();
  end

  initial begin
    void'($urandom(74));
    repeat (6) @(negedge i_clock);
    i_rst_n = 1'b1;
    check_eq({6'h00, drv_a, drv_b}, 8'h00);
    // Whole map after reset, one unmapped place included.
    for (int i = 0; i < 8; i++) begin
      rdr(8'h56 + 8'(i));
      check_eq(rd, (i == 2) ? RST_CONFIG : 8'h00);
    end
    // Duty over one period for the fast clock choices; first case takes both extremes.
    for (int k = 0; k < 4; k++) begin
      idx = {k[1], 1'b0, k[0]};
      da = (k == 0) ? 6'h00 : 6'($urandom_range(63));
      db = (k == 0) ? 6'h3F : 6'($urandom_range(63));
      wr(ADDR_CONFIG, {4'h5, idx[2], idx[2], 2'b00});
      wr(ADDR_DRIVE_A, {idx[0], da, 1'b0});
      wr(ADDR_DRIVE_B, {idx[0], db, 1'b0});
      st = CLK_HZ / (FOUT_HZ[idx] * 64);
      repeat (128 * st) @(negedge i_clock);
      measure(64 * st);
      check_rng(16'(ha), da * st, da * st);
      check_rng(16'(hb), db * st, db * st);
    end
    // Override holds both outputs high whatever the duty.
    wr(ADDR_DRIVE_A, 8'h01);
    wr(ADDR_DRIVE_B, 8'h7F);
    repeat (3) @(negedge i_clock);
    measure(200);
    check_rng(16'(ha + hb), 400, 400);
    // Count at or above 192 raises only the enabled outputs.
    wake_en = 2'b01;
    smi_en = 2'b10;
    wr(ADDR_PRELOAD_A, 8'hC0);
    wr(ADDR_PRELOAD_B, 8'hC0);
    repeat (4) @(negedge i_clock);
    check_eq({6'h00, wake, sysmgmt_interrupt}, 8'h03);
    wake_en = 2'b10;
    smi_en = 2'b00;
    wr(ADDR_PRELOAD_B, 8'h00);
    repeat (4) @(negedge i_clock);
    check_eq({6'h00, wake, sysmgmt_interrupt}, 8'h00);
    // A preload write restarts the count at the new value.
    p = $urandom_range(255);
    wr(ADDR_PRELOAD_A, 8'(p));
    rdr(ADDR_COUNT_A);
    check_rng({8'h00, rd}, p, (p < 255) ? p + 1 : p);
    // Software's recommended preload of 32 for the 70% failure point.
    wr(ADDR_PRELOAD_B, 8'h20);
    rdr(ADDR_COUNT_B);
    check_rng({8'h00, rd}, 32, 33);
    wr(ADDR_CONFIG, 8'h10);
    wr(ADDR_PRELOAD_A, 8'hF0);
    repeat (20 * SLOW_DIV) @(negedge i_clock);
    rdr(ADDR_COUNT_A);
    check_eq(rd, COUNT_MAX);
    // Each divisor code gives 4 increments over 4 * 2^d slow ticks.
    for (int d = 0; d < 4; d++) begin
      wr(ADDR_CONFIG, {d[1:0], d[1:0], 4'h0});
      wr(ADDR_PRELOAD_A, 8'h00);
      wr(ADDR_PRELOAD_B, 8'h00);
      repeat (4 * (1 << d) * SLOW_DIV) @(negedge i_clock);
      rdr(ADDR_COUNT_A);
      check_rng({8'h00, rd}, 3, 5);
      rdr(ADDR_COUNT_B);
      check_rng({8'h00, rd}, 3, 5);
    end
    // External slow clock selected: ten of its ticks in the window.
    present = 1'b1;
    wr(ADDR_CONFIG, 8'h00);
    wr(ADDR_PRELOAD_A, 8'h00);
    repeat (3052) @(negedge i_clock);
    rdr(ADDR_COUNT_A);
    check_rng({8'h00, rd}, 9, 11);
    present = 1'b0;
    // Spinning fans: the count climbs between pulses and falls back on each rise.
    wr(ADDR_CONFIG, RST_CONFIG);
    p = $urandom_range(63);
    q = $urandom_range(63);
    wr(ADDR_PRELOAD_A, 8'(p));
    wr(ADDR_PRELOAD_B, 8'(q));
    run = 1'b1;
    @(posedge tach_a);
    @(negedge tach_a);
    rdr(ADDR_COUNT_A);
    check_rng({8'h00, rd}, p + 2, p + 4);
    @(posedge tach_a);
    repeat (6) @(negedge i_clock);
    rdr(ADDR_COUNT_A);
    check_rng({8'h00, rd}, p, p + 1);
    @(posedge tach_b);
    repeat (6) @(negedge i_clock);
    rdr(ADDR_COUNT_B);
    check_rng({8'h00, rd}, q, q + 1);
    run = 1'b0;
    end_of_test();
  end
endmodule : tb
